// >>> gpio_port_pkg.sv
// Constants shared by the general purpose I/O port
package gpio_port_pkg;
  localparam int          PORT_WIDTH     = 8;
  localparam int          REG_SEL_WIDTH  = 2;
  // Register select codes on the core write/read port
  localparam logic [1:0]  SEL_OUTPUT     = 2'h0;
  localparam logic [1:0]  SEL_DIRECTION  = 2'h1;
  localparam logic [1:0]  SEL_PULLUP     = 2'h2;
  localparam logic [1:0]  SEL_SAMPLED    = 2'h3;
  // Reset values
  localparam logic [7:0]  RESET_OUTPUT    = 8'h00;
  localparam logic [7:0]  RESET_DIRECTION = 8'h00;
  localparam logic [7:0]  RESET_PULLUP    = 8'h00;
  localparam logic [7:0]  RESET_SAMPLED   = 8'h00;
endpackage

// >>> general_purpose_io_port.sv
// General purpose I/O port: registers, pin drive, pull-ups and input synchroniser
// What this block does
// [RQ1] Single-bit writes change only the selected bit of a port register.
// [RQ2] Four register selects: output data, direction, pull-up select, sampled level.
// [RQ3] Sampled level register is read only; output and direction read/write.
// [RQ4] Writing one to sampled level bit toggles output data bit.
// [RQ5] Global pull-up disable turns off every pull-up.
// [RQ6] Direction one makes pin output, zero makes it input.
// [RQ7] Pull-up only for input pin with output bit one and no disable.
// [RQ8] Output pin drives output data bit, no pull-up.
// [RQ9] Reset tri-states all pins at once, clock not needed.
// [RQ10] Software passes pull-up or drive-low between floating and drive-high.
// [RQ11] Software passes floating or drive-high between pull-up and drive-low.
// [RQ12] Pin level readable via latch plus sampling register in either direction, except while clamped in deep sleep.
// [RQ13] Latch transparent on clock high; register loads at next rising edge.
// [RQ14] Software-driven value reaches sampling register after one clock period.
// [RQ15] Alternate functions on some pins leave the others untouched.
// [RQ16] Deep sleep clamps input low unless interrupt or override enabled.
// [RQ17] After reset output, direction and pull-up registers read zero.
`timescale 1ns/10ps
module general_purpose_io_port
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
)(
  // Clock and reset
  input  wire logic                     I_CLK,
  input  wire logic                     I_RSTN,
  // Core register access
  input  wire logic                     I_WR_EN,
  input  wire logic                     I_BIT_EN,
  input  wire logic [2:0]               I_BIT_IDX,
  input  wire logic                     I_BIT_VAL,
  input  wire logic [REG_SEL_WIDTH-1:0] I_SEL,
  input  wire logic [WIDTH-1:0]         I_WDATA,
  input  wire logic                     I_RD_EN,
  output logic      [WIDTH-1:0]         O_RDATA,
  // Chip level controls
  input  wire logic                     I_GLOBAL_PULLUP_DISABLE,
  input  wire logic                     I_SLEEP_CLAMP,
  input  wire logic [WIDTH-1:0]         I_EXT_INT_EN,
  input  wire logic [WIDTH-1:0]         I_ALT_INPUT_KEEP,
  // Pins
  input  wire logic [WIDTH-1:0]         I_PIN,
  output logic      [WIDTH-1:0]         O_PIN,
  output logic      [WIDTH-1:0]         O_PIN_OE_N,
  output logic      [WIDTH-1:0]         O_PULLUP_EN,
  // Unsynchronised input for alternate functions
  output logic      [WIDTH-1:0]         O_DIGITAL_IN
);

  // Pin states as {direction bit, output bit}:
  //   00 floating input
  //   01 pulled-up input if its pull-up select bit is set and pull-ups are not disabled
  //   10 driven low
  //   11 driven high
  // Direct moves 00<->11 and 01<->10 glitch the pin.
  // Software must step through one of the other two states.
  // This logic does not police the order of writes.

  // Clocked register state of the port, apart from the pin control registers oe_n and pullup_en
  typedef struct packed {
    logic [WIDTH-1:0] output_data_reg;
    logic [WIDTH-1:0] direction_reg;
    logic [WIDTH-1:0] pullup_select_reg;
    logic [WIDTH-1:0] sampled_level_reg;
    logic [WIDTH-1:0] rdata;
    logic [WIDTH-1:0] pin_out;
  } state_s;

  // Register state and its next value
  state_s           state;
  state_s           next_state;

  // Pin input path
  logic [WIDTH-1:0] gated_in;       // Clamped pad level
  logic [WIDTH-1:0] sync_latch;     // First synchroniser stage

  // Write decode helpers
  logic [WIDTH-1:0] wr_mask;        // Bits touched by this write
  logic [WIDTH-1:0] wr_bits;        // Values for touched bits

  // Pin control registers with asynchronous reset
  logic [WIDTH-1:0] oe_n;
  logic [WIDTH-1:0] pullup_en;
  logic [WIDTH-1:0] next_pullup_en;

  // Write mask: one bit for single-bit access, all bits otherwise
  // Keeps neighbour pins intact on bit set or clear
  always_comb
  begin
    wr_mask = '1;
    wr_bits = I_WDATA;
    if (I_BIT_EN)
    begin
      wr_mask            = '0;
      wr_mask[I_BIT_IDX] = 1'b1;                                // [RQ1]
      wr_bits            = {WIDTH{I_BIT_VAL}};
    end
  end

  // Per-pin input gating and transparent-high synchroniser latch
  // Clamp sits ahead of the latch so floating pads draw no current
  // Alternate-function pins keep their input live in any state
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_pin
      assign gated_in[g] = I_PIN[g]
                           & ~(I_SLEEP_CLAMP & ~I_EXT_INT_EN[g] & ~I_ALT_INPUT_KEEP[g]); // [RQ16] [RQ15]
      always_latch
      begin
        if (I_CLK)
          sync_latch[g] <= gated_in[g];                         // [RQ13]
      end
    end
  endgenerate

  // Next state of registers and read data
  always_comb
  begin
    next_state = state;
    // Register writes; the sampled select only toggles, never stores
    if (I_WR_EN)
    begin
      case (I_SEL)                                              // [RQ2]
        SEL_OUTPUT:
        begin
          next_state.output_data_reg = (state.output_data_reg & ~wr_mask) | (wr_bits & wr_mask); // [RQ1]
        end
        SEL_DIRECTION:
        begin
          next_state.direction_reg = (state.direction_reg & ~wr_mask) | (wr_bits & wr_mask);     // [RQ1]
        end
        SEL_PULLUP:
        begin
          next_state.pullup_select_reg = (state.pullup_select_reg & ~wr_mask) | (wr_bits & wr_mask); // [RQ1]
        end
        SEL_SAMPLED:
        begin
          next_state.output_data_reg = state.output_data_reg ^ (wr_bits & wr_mask); // [RQ4] [RQ3]
        end
        default:
        begin
          next_state = state;
        end
      endcase
    end

    // Second synchroniser stage takes the held latch value
    next_state.sampled_level_reg = sync_latch;                  // [RQ12] [RQ13] [RQ14]

    // Read data captured on a read strobe, held otherwise
    if (I_RD_EN)
    begin
      case (I_SEL)
        SEL_OUTPUT:
        begin
          next_state.rdata = state.output_data_reg;
        end
        SEL_DIRECTION:
        begin
          next_state.rdata = state.direction_reg;
        end
        SEL_PULLUP:
        begin
          next_state.rdata = state.pullup_select_reg;
        end
        SEL_SAMPLED:
        begin
          next_state.rdata = state.sampled_level_reg;
        end
        default:
        begin
          next_state.rdata = '0;
        end
      endcase
    end

    // Drive value follows the output data register
    next_state.pin_out = next_state.output_data_reg;            // [RQ8]
  end

  // Pull-up request: input pin, output bit one, selected, not disabled
  assign next_pullup_en = ~next_state.direction_reg
                          & next_state.output_data_reg
                          & next_state.pullup_select_reg
                          & {WIDTH{~I_GLOBAL_PULLUP_DISABLE}};  // [RQ5] [RQ7]

  // State register, synchronous reset
  always_ff @(posedge I_CLK)
  begin
    if (!I_RSTN)
    begin
      state.output_data_reg   <= RESET_OUTPUT[WIDTH-1:0];       // [RQ17]
      state.direction_reg     <= RESET_DIRECTION[WIDTH-1:0];    // [RQ17]
      state.pullup_select_reg <= RESET_PULLUP[WIDTH-1:0];       // [RQ17]
      state.sampled_level_reg <= RESET_SAMPLED[WIDTH-1:0];
      state.rdata             <= '0;
      state.pin_out           <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Output enable and pull-up registers
  // Reset floats pins and drops pull-ups with no clock edge needed
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      oe_n      <= '1;                                          // [RQ9]
      pullup_en <= '0;
    end
    else
    begin
      oe_n      <= ~next_state.direction_reg;                   // [RQ6]
      pullup_en <= next_pullup_en;                              // [RQ7]
    end
  end

  // Outputs, all from flip-flops except the raw alternate-function input
  assign O_RDATA      = state.rdata;
  assign O_PIN        = state.pin_out;
  assign O_PIN_OE_N   = oe_n;
  assign O_PULLUP_EN  = pullup_en;
  // Unsynchronised by intent; the consumer brings its own synchroniser
  assign O_DIGITAL_IN = gated_in;

endmodule

// >>> gpio_port_props.sv
// Pin and register-write checks for the I/O port
`timescale 1ns/10ps
module gpio_port_props
  import gpio_port_pkg::*;
(
  // Watched ports
  input wire logic       I_CLK, I_RSTN, I_WR_EN, I_BIT_EN, I_GLOBAL_PULLUP_DISABLE, I_SLEEP_CLAMP,
  input wire logic [2:0] I_BIT_IDX,
  input wire logic [1:0] I_SEL,
  input wire logic [7:0] I_WDATA, I_EXT_INT_EN, I_ALT_INPUT_KEEP, O_PIN, O_PIN_OE_N, O_PULLUP_EN, O_DIGITAL_IN
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  // Reset holds every pin undriven
  property p_rst; disable iff (1'b0) !I_RSTN |-> O_PIN_OE_N == 8'hFF; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_dir; I_WR_EN && !I_BIT_EN && I_SEL == SEL_DIRECTION |=> O_PIN_OE_N == ~$past(I_WDATA); endproperty
  a_dir: assert property (p_dir) else $error("dir");
  property p_out; I_WR_EN && !I_BIT_EN && I_SEL == SEL_OUTPUT |=> O_PIN == $past(I_WDATA); endproperty
  a_out: assert property (p_out) else $error("out");
  property p_bit; I_WR_EN && I_BIT_EN && I_SEL == SEL_DIRECTION
    |=> ((O_PIN_OE_N ^ $past(O_PIN_OE_N)) & ~(8'h01 << $past(I_BIT_IDX))) == 8'h00; endproperty
  a_bit: assert property (p_bit) else $error("bit");
  property p_tog; I_WR_EN && !I_BIT_EN && I_SEL == SEL_SAMPLED |=> O_PIN == ($past(O_PIN) ^ $past(I_WDATA)); endproperty
  a_tog: assert property (p_tog) else $error("tog");
  property p_gpd; I_GLOBAL_PULLUP_DISABLE [*2] |-> O_PULLUP_EN == 8'h00; endproperty
  a_gpd: assert property (p_gpd) else $error("gpd");
  property p_pu; (O_PULLUP_EN & ~(O_PIN_OE_N & O_PIN)) == 8'h00; endproperty
  a_pu: assert property (p_pu) else $error("pu");
  property p_clamp; I_SLEEP_CLAMP |-> (O_DIGITAL_IN & ~(I_EXT_INT_EN | I_ALT_INPUT_KEEP)) == 8'h00; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp");
endmodule
bind general_purpose_io_port gpio_port_props props (.*);

// >>> gpio_pads.sv
// External circuitry on the port pins
`timescale 1ns/10ps
module gpio_pads (
  // Port side and external drive
  input  wire logic       i_clk,
  input  wire logic [7:0] i_pin, i_oe_n, i_pu, i_ext_en, i_ext_val,
  output logic      [7:0] o_pad
);
  logic [7:0] last = 8'h00;
  // Driver wins, then external drive, then pull-up, else a wandering float
  assign o_pad = (~i_oe_n & i_pin) | (i_oe_n & i_ext_en & i_ext_val) | (i_oe_n & ~i_ext_en & (i_pu | ~last));
  always_ff @(posedge i_clk) last <= o_pad;
endmodule

// >>> tb.sv
// Self-checking bench for the I/O port
`timescale 1ns/10ps
module tb;
  import gpio_port_pkg::*;
  logic       clk = 0, rstn = 1, we = 0, be = 0, bv = 0, re = 0, gpd = 0, slp = 0;
  logic [2:0] bx = 0;
  logic [1:0] sel = 0;
  logic [7:0] wd = 0, ein = 0, alt = 0, een = 0, ev = 0, pad, rdat, opin, oen, pu, din;
  int         n_errors = 0, comparisons = 0;
  general_purpose_io_port dut (.I_CLK(clk), .I_RSTN(rstn), .I_WR_EN(we), .I_BIT_EN(be), .I_BIT_IDX(bx), .I_BIT_VAL(bv),
    .I_SEL(sel), .I_WDATA(wd), .I_RD_EN(re), .O_RDATA(rdat), .I_GLOBAL_PULLUP_DISABLE(gpd), .I_SLEEP_CLAMP(slp),
    .I_EXT_INT_EN(ein), .I_ALT_INPUT_KEEP(alt), .I_PIN(pad), .O_PIN(opin), .O_PIN_OE_N(oen), .O_PULLUP_EN(pu),
    .O_DIGITAL_IN(din));
  gpio_pads pads (.i_clk(clk), .i_pin(opin), .i_oe_n(oen), .i_pu(pu), .i_ext_en(een), .i_ext_val(ev), .o_pad(pad));
  // Compare and count
  task chk(string n, logic [7:0] s, logic [7:0] e);
    comparisons++;
    if (s !== e) n_errors++;
    if (s !== e) $display("mismatch %s expected %h seen %h", n, e, s);
  endtask
  // One-cycle write, optionally a single bit
  task wr(logic [1:0] s, logic [7:0] d, logic b = 0, logic [2:0] x = 0, logic v = 0);
    @(negedge clk); we = 1; sel = s; wd = d; be = b; bx = x; bv = v;
    @(negedge clk); we = 0;
  endtask
  // Read and compare
  task rd(logic [1:0] s, logic [7:0] e, string n);
    @(negedge clk); re = 1; sel = s;
    @(negedge clk); re = 0;
    @(negedge clk); chk(n, rdat, e);
  endtask
  task t_reset;
    rd(SEL_OUTPUT, 8'h00, "out");
    rd(SEL_DIRECTION, 8'h00, "dir");
    rd(SEL_PULLUP, 8'h00, "pue");
  endtask
  // Drive via pull-up step, bit write, toggle
  task t_drive;
    wr(SEL_OUTPUT, 8'h5A); wr(SEL_DIRECTION, 8'hFF);
    chk("pad", pad, 8'h5A);
    rd(SEL_SAMPLED, 8'h5A, "smp");
    wr(SEL_DIRECTION, 8'h00, 1, 3'h2, 0);
    chk("oen", oen, 8'h04);
    wr(SEL_SAMPLED, 8'h0F);
    rd(SEL_OUTPUT, 8'h55, "tgl");
  endtask
  // Pull-ups, clamp, global disable, mid-run reset
  task t_pull;
    wr(SEL_DIRECTION, 8'h00); wr(SEL_OUTPUT, 8'hF0); wr(SEL_PULLUP, 8'hFF);
    chk("pu", pu, 8'hF0);
    een = 8'h0F; ev = 8'h0A;
    @(negedge clk);
    rd(SEL_SAMPLED, 8'hFA, "smp");
    slp = 1; ein = 8'h02; alt = 8'h80; #1;
    chk("din", din, 8'h82);
    @(negedge clk); slp = 0; gpd = 1;
    @(negedge clk); @(negedge clk); chk("pu", pu, 8'h00);
    @(negedge clk); gpd = 0;
    @(negedge clk); chk("pu", pu, 8'hF0);
    rstn = 0;
    #1 chk("oen", oen, 8'hFF);
    chk("pu", pu, 8'h00);
    repeat (4) @(negedge clk);
    rstn = 1;
    t_reset;
  endtask
  task end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial forever #25 clk = ~clk;
  // Watchdog
  initial
  begin
    #20000 n_errors++;
    end_of_test;
  end
  initial
  begin
    #1 rstn = 0;
    #1 chk("oen", oen, 8'hFF);
    repeat (4) @(posedge clk);
    @(negedge clk) rstn = 1;
    t_reset;
    t_drive;
    t_pull;
    end_of_test;
  end
endmodule
